/* File: rtl/pin_change_pkg.sv */
// shared constants and types for the pin-change interrupt block
package pin_change_pkg;

  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;

  // register offsets
  localparam logic [3:0] RISE_EDGE_ENABLE_OFS = 4'h0;
  localparam logic [3:0] FALL_EDGE_ENABLE_OFS = 4'h1;
  localparam logic [3:0] PIN_CHANGE_FLAG_OFS  = 4'h2;
  localparam logic [3:0] CORE_INT_CONTROL_OFS = 4'h3;
  localparam logic [3:0] IRQ_STATUS_OFS       = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFS         = 4'h5;

  // field positions of the core interrupt control register
  localparam int unsigned ANY_FLAG_POS   = 0;
  localparam int unsigned INT_ENABLE_POS = 3;

  // interrupt status / mask layout
  localparam int unsigned EVT_EDGE_POS = 0;
  localparam int unsigned EVT_WAKE_POS = 1;
  localparam int unsigned EVT_W        = 2;

  // reset values
  localparam logic [5:0] PIN_REG_RST = 6'h00;
  localparam logic       INT_EN_RST  = 1'b0;
  localparam logic [1:0] EVT_RST     = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] rise_en;
    logic [PIN_COUNT-1:0] fall_en;
  } edge_cfg_t;

endpackage : pin_change_pkg

/* File: rtl/pin_change_edge_interrupt.sv */
// per-pin edge detector, sticky flags and interrupt request for the first port
`timescale 1ns/1ps
module pin_change_edge_interrupt
  import pin_change_pkg::*;
(
  // clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  // port pins
  input  wire logic [PIN_COUNT-1:0] FIRST_PORT_PINS,
  // sleep state of the core
  input  wire logic                 SLEEP_ACTIVE,
  // register port
  input  wire logic [ADDR_W-1:0]    REG_ADDR,
  input  wire logic [DATA_W-1:0]    REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [DATA_W-1:0]    REG_RDATA,
  // requests to the core
  output logic                      PIN_CHANGE_IRQ,
  output logic                      WAKE_REQ,
  output logic                      IRQ_OUT
);

  // register port request
  reg_req_t             req;

  // edge enables
  edge_cfg_t            cfg_q;
  edge_cfg_t            cfg_d;

  // pin sampling chain
  logic [PIN_COUNT-1:0] sync1_q;
  logic [PIN_COUNT-1:0] sync1_d;
  logic [PIN_COUNT-1:0] sync2_q;
  logic [PIN_COUNT-1:0] sync2_d;
  logic [PIN_COUNT-1:0] prev_q;
  logic [PIN_COUNT-1:0] prev_d;

  // pin flags and master enable
  logic [PIN_COUNT-1:0] flag_q;
  logic [PIN_COUNT-1:0] flag_d;
  logic                 int_en_q;
  logic                 int_en_d;

  // sticky interrupt status and mask
  logic [EVT_W-1:0]     evt_q;
  logic [EVT_W-1:0]     evt_d;
  logic [EVT_W-1:0]     mask_q;
  logic [EVT_W-1:0]     mask_d;
  logic [EVT_W-1:0]     evt_set;

  // read data and requests
  logic [DATA_W-1:0]    rdata_q;
  logic [DATA_W-1:0]    rdata_d;
  logic                 irq_q;
  logic                 irq_d;
  logic                 wake_q;
  logic                 wake_d;

  // decoded edges
  logic [PIN_COUNT-1:0] rise_seen;
  logic [PIN_COUNT-1:0] fall_seen;
  logic [PIN_COUNT-1:0] edge_hit;

  // summaries
  logic                 any_edge;
  logic                 any_flag;
  logic                 any_flag_next;

  // write strobes per register
  logic                 wr_rise_en;
  logic                 wr_fall_en;
  logic                 wr_flag;
  logic                 wr_ctrl;
  logic                 wr_status;
  logic                 wr_mask;

  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  function automatic logic wr_hit(input reg_req_t r, input logic [3:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction : wr_hit

  assign wr_rise_en = wr_hit(req, RISE_EDGE_ENABLE_OFS);
  assign wr_fall_en = wr_hit(req, FALL_EDGE_ENABLE_OFS);
  assign wr_flag    = wr_hit(req, PIN_CHANGE_FLAG_OFS);
  assign wr_ctrl    = wr_hit(req, CORE_INT_CONTROL_OFS);
  assign wr_status  = wr_hit(req, IRQ_STATUS_OFS);
  assign wr_mask    = wr_hit(req, IRQ_MASK_OFS);

  // one rise and one fall detector per pin
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      assign rise_seen[g] = sync2_q[g] & ~prev_q[g];
      assign fall_seen[g] = ~sync2_q[g] & prev_q[g];
      assign edge_hit[g]  = (rise_seen[g] & cfg_q.rise_en[g])
                          | (fall_seen[g] & cfg_q.fall_en[g]);
    end
  endgenerate

  // summaries of the pin vectors
  assign any_edge      = |edge_hit;
  assign any_flag      = |flag_q;
  assign any_flag_next = |flag_d;

  // synchroniser: only the second stage feeds the detector
  always_comb begin
    sync1_d = FIRST_PORT_PINS;
    sync2_d = sync1_q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // previous sample; resets to zero, so a pin that is high after reset shows a rising edge
  always_comb begin
    prev_d = sync2_q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // edge enables
  always_comb begin
    cfg_d = cfg_q;
    if (wr_rise_en) begin
      cfg_d.rise_en = req.wdata[PIN_COUNT-1:0];
    end
    if (wr_fall_en) begin
      cfg_d.fall_en = req.wdata[PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cfg_q <= '{rise_en: PIN_REG_RST, fall_en: PIN_REG_RST};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // master enable
  always_comb begin
    int_en_d = int_en_q;
    if (wr_ctrl) begin
      int_en_d = req.wdata[INT_ENABLE_POS];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      int_en_q <= INT_EN_RST;
    end else begin
      int_en_q <= int_en_d;
    end
  end

  // pin flags: a write replaces the value, a new edge in that cycle wins
  // software clears by writing zeros; a written one sets that flag
  always_comb begin
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = req.wdata[PIN_COUNT-1:0];
    end
    flag_d = flag_d | edge_hit;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      flag_q <= PIN_REG_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  // sticky status: a hardware set wins over a write-one clear
  always_comb begin
    evt_set               = '0;
    evt_set[EVT_EDGE_POS] = any_edge;
    // a wake event needs the master enable, as the wake request does
    evt_set[EVT_WAKE_POS] = any_edge & SLEEP_ACTIVE & int_en_q;
    evt_d = evt_q;
    if (wr_status) begin
      evt_d = evt_q & ~req.wdata[EVT_W-1:0];
    end
    evt_d = evt_d | evt_set;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      evt_q <= EVT_RST;
    end else begin
      evt_q <= evt_d;
    end
  end

  // interrupt mask
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = req.wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mask_q <= EVT_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // pin-change request follows the flags in the cycle they are written
  always_comb begin
    irq_d = int_en_q & any_flag_next;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // wake level needs the core to report its sleep state
  always_comb begin
    wake_d = int_en_q & SLEEP_ACTIVE & any_flag_next;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  // read data stands one cycle after the read strobe, else zero
  // map: 0 rise enables, 1 fall enables, 2 pin flags, 3 core control,
  // 4 interrupt status (write one to clear), 5 interrupt mask
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      unique case (req.addr)
        RISE_EDGE_ENABLE_OFS: rdata_d[PIN_COUNT-1:0] = cfg_q.rise_en;
        FALL_EDGE_ENABLE_OFS: rdata_d[PIN_COUNT-1:0] = cfg_q.fall_en;
        PIN_CHANGE_FLAG_OFS:  rdata_d[PIN_COUNT-1:0] = flag_q;
        CORE_INT_CONTROL_OFS: begin
          rdata_d[INT_ENABLE_POS] = int_en_q;
          rdata_d[ANY_FLAG_POS]   = any_flag;
        end
        IRQ_STATUS_OFS:       rdata_d[EVT_W-1:0] = evt_q;
        IRQ_MASK_OFS:         rdata_d[EVT_W-1:0] = mask_q;
        default:              rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs
  assign REG_RDATA      = rdata_q;
  assign PIN_CHANGE_IRQ = irq_q;
  assign WAKE_REQ       = wake_q;
  assign IRQ_OUT        = |(evt_q & mask_q);

endmodule : pin_change_edge_interrupt

/* File: sim/pin_change_edge_interrupt_asserts.sv */
// port-level checks of the pin-change interrupt block
`timescale 1ns/1ps
module pin_change_edge_interrupt_asserts
  import pin_change_pkg::*;
(
  // clock and reset
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  // core state and register port
  input wire logic              SLEEP_ACTIVE,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // requests
  input wire logic              PIN_CHANGE_IRQ,
  input wire logic              WAKE_REQ,
  input wire logic              IRQ_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  AST_RD_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data not idle");
  AST_RD_TOP: assert property ($past(REG_RD) && $past(REG_ADDR) < 4'h3
    |-> REG_RDATA[7:6] == 2'h0) else $error("upper pin bits set");
  AST_RD_GAP: assert property ($past(REG_RD) && $past(REG_ADDR) > 4'h5
    |-> REG_RDATA == 8'h00) else $error("unmapped read not zero");
  AST_CTRL_IRQ: assert property ($past(REG_RD) && $past(REG_ADDR) == CORE_INT_CONTROL_OFS
    |-> PIN_CHANGE_IRQ == (REG_RDATA[INT_ENABLE_POS] & REG_RDATA[ANY_FLAG_POS]))
    else $error("request disagrees with control");
  AST_EN_OFF: assert property (REG_WR && REG_ADDR == CORE_INT_CONTROL_OFS
    && !REG_WDATA[INT_ENABLE_POS] |-> ##2 !PIN_CHANGE_IRQ) else $error("request without enable");
  AST_STICKY: assert property ($fell(PIN_CHANGE_IRQ) |->
    $past(REG_WR && REG_ADDR == PIN_CHANGE_FLAG_OFS)
    || $past(REG_WR && REG_ADDR == CORE_INT_CONTROL_OFS, 2))
    else $error("request fell without a write");
  AST_WAKE: assert property (WAKE_REQ == (PIN_CHANGE_IRQ && $past(SLEEP_ACTIVE)))
    else $error("wake level wrong");
  AST_MASK: assert property (REG_WR && REG_ADDR == IRQ_MASK_OFS
    && REG_WDATA[1:0] == 2'h0 |=> !IRQ_OUT) else $error("masked interrupt high");
  cover property (WAKE_REQ);
  cover property ($fell(PIN_CHANGE_IRQ));
  cover property (IRQ_OUT);
endmodule : pin_change_edge_interrupt_asserts

/* File: sim/pin_source.sv */
// far-side pin driver, following the bench level promptly or one cycle late
`timescale 1ns/1ps
module pin_source
  import pin_change_pkg::*;
(
  // clock
  input  wire logic                 CLK_SYS,
  // requested level and pace
  input  wire logic [PIN_COUNT-1:0] LEVEL,
  input  wire logic                 SLOW,
  // pins
  output logic      [PIN_COUNT-1:0] PINS = '0
);
  logic [PIN_COUNT-1:0] held_q = '0;
  always @(posedge CLK_SYS) begin
    held_q <= LEVEL;
    PINS   <= SLOW ? held_q : LEVEL;
  end
endmodule : pin_source

/* File: sim/pin_change_edge_interrupt_bench.sv */
// self-checking bench for the pin-change interrupt block
`timescale 1ns/1ps
module pin_change_edge_interrupt_bench import pin_change_pkg::*;;
  logic CLK_SYS, RST_N, SLEEP_ACTIVE, REG_WR, REG_RD, PIN_CHANGE_IRQ, WAKE_REQ, IRQ_OUT, slow;
  logic [ADDR_W-1:0]    REG_ADDR;
  logic [DATA_W-1:0]    REG_WDATA, REG_RDATA;
  logic [PIN_COUNT-1:0] FIRST_PORT_PINS, lvl;
  logic [31:0]          seed = 32'h40;
  int miscompares = 0, check_count = 0, cycles = 0, rise_m, fall_m, flag_m = 0, old_m = 0, d;
  pin_change_edge_interrupt dut (.CLK_SYS, .RST_N, .FIRST_PORT_PINS, .SLEEP_ACTIVE, .REG_ADDR,
    .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PIN_CHANGE_IRQ, .WAKE_REQ, .IRQ_OUT);
  pin_source src (.CLK_SYS, .LEVEL(lvl), .SLOW(slow), .PINS(FIRST_PORT_PINS));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge CLK_SYS);
    REG_ADDR  <= a;
    REG_WDATA <= v;
    REG_WR    <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR    <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] exp);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD   <= 1'b0;
    #1 chk(REG_RDATA, exp);
  endtask : rd
  // new level at one edge; model flags follow the enabled edges
  task automatic pin(logic [5:0] v, int n);
    @(posedge CLK_SYS);
    lvl <= v;
    flag_m |= (rise_m & ~old_m & v) | (fall_m & old_m & ~v);
    old_m = v;
    repeat (n) @(posedge CLK_SYS);
  endtask : pin
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) if (++cycles == 4000) begin
    miscompares++;
    summarize();
  end
  initial begin
    {RST_N, SLEEP_ACTIVE, REG_WR, REG_RD, REG_ADDR, REG_WDATA, lvl, slow} = '0;
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    for (d = 0; d < 6; d++) rd(d[3:0], 8'h00);
    rd(4'hf, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      rise_m = xs() & 63;
      fall_m = xs() & 63;
      slow <= seed[3];
      wr(RISE_EDGE_ENABLE_OFS, 8'(rise_m));
      wr(FALL_EDGE_ENABLE_OFS, 8'(fall_m));
      pin(6'(xs()), 7);
      rd(PIN_CHANGE_FLAG_OFS, 8'(flag_m));
      rd(CORE_INT_CONTROL_OFS, {7'h0, flag_m != 0});
      if (i[0]) wr(PIN_CHANGE_FLAG_OFS, 8'(flag_m) & ~8'(flag_m));
      if (i[0]) flag_m = 0;
    end
    $display("test edges done");
    wr(IRQ_MASK_OFS, 8'h03);
    wr(IRQ_STATUS_OFS, 8'h03);
    #1 chk({7'h0, IRQ_OUT}, 8'h00);
    wr(CORE_INT_CONTROL_OFS, 8'h08);
    SLEEP_ACTIVE <= 1'b1;
    rise_m = 63;
    fall_m = 63;
    wr(RISE_EDGE_ENABLE_OFS, 8'h3f);
    wr(FALL_EDGE_ENABLE_OFS, 8'h3f);
    pin(6'(~old_m), 7);
    #1 chk({5'h0, PIN_CHANGE_IRQ, WAKE_REQ, IRQ_OUT}, 8'h07);
    rd(IRQ_STATUS_OFS, 8'h03);
    wr(PIN_CHANGE_FLAG_OFS, 8'h00);
    rd(CORE_INT_CONTROL_OFS, 8'h08);
    chk({7'h0, PIN_CHANGE_IRQ}, 8'h00);
    wr(IRQ_MASK_OFS, 8'h00);
    #1 chk({7'h0, IRQ_OUT}, 8'h00);
    $display("test interrupt done");
    slow <= 1'b0;
    for (d = 0; d < 6; d++) begin
      pin(6'(~old_m), d);
      wr(PIN_CHANGE_FLAG_OFS, 8'h00);
      repeat (6) @(posedge CLK_SYS);
      rd(PIN_CHANGE_FLAG_OFS, (d <= 2) ? 8'h3f : 8'h00);
    end
    $display("test clear race done");
    pin(6'(~old_m), 7);
    #1 chk({7'h0, PIN_CHANGE_IRQ}, 8'h01);
    wr(CORE_INT_CONTROL_OFS, 8'h00);
    repeat (2) @(posedge CLK_SYS);
    #1 chk({7'h0, PIN_CHANGE_IRQ}, 8'h00);
    rd(CORE_INT_CONTROL_OFS, 8'h01);
    rd(PIN_CHANGE_FLAG_OFS, 8'h3f);
    $display("test enable off done");
    summarize();
  end
endmodule : pin_change_edge_interrupt_bench
bind pin_change_edge_interrupt pin_change_edge_interrupt_asserts chk_i (.CLK_SYS, .RST_N,
  .SLEEP_ACTIVE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PIN_CHANGE_IRQ,
  .WAKE_REQ, .IRQ_OUT);
